// [tb/alcf_host.sv]
`timescale 1ns/100ps
// ========================================
// host model: sends request frames, collects output bytes
module alcf_host
	import alcf_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rx_ready,
	input  wire logic [7:0] tx_data,
	input  wire logic       tx_valid,
	output logic      [7:0] rx_data,
	output logic            rx_valid,
	output logic            tx_ready
);
	typedef logic [7:0] alcf_hq_t[$];
	logic [7:0] got[$];
	logic       stall;
	logic       escaped;
	initial
	begin
		rx_data = 8'h00;
		rx_valid = 1'b0;
		tx_ready = 1'b1;
		stall = 1'b0;
		escaped = 1'b0;
	end
	// escaped mode: every special byte after the delimiter
	function automatic alcf_hq_t escape_q(input alcf_hq_t q);
		alcf_hq_t r;
		r = {};
		foreach (q[i])
			if (escaped && i > 0 && (q[i] == START_DELIM
				|| q[i] == ESC_BYTE || q[i] == XON_BYTE
				|| q[i] == XOFF_BYTE))
				r = {r, ESC_BYTE, q[i] ^ ESC_FLIP};
			else
				r = {r, q[i]};
		return r;
	endfunction
	// take output bytes; stalls every other cycle when asked
	always @(posedge clk)
	begin
		if (tx_valid && tx_ready)
			got.push_back(tx_data);
		tx_ready <= stall ? ~tx_ready : 1'b1;
	end
	// delimiter, length msb first, data, checksum
	task automatic send(input logic [7:0] body[$], input logic bad);
		logic [7:0] f[$];
		logic [7:0] s;
		s = 8'h00;
		foreach (body[i])
			s = s + body[i];
		f = {START_DELIM, 8'h00, 8'(body.size())};
		f = {f, body, (CKSUM_TOTAL - s) ^ {7'h00, bad}};
		f = escape_q(f);
		foreach (f[i])
		begin
			rx_data <= f[i];
			rx_valid <= 1'b1;
			@(posedge clk);
			while (!rx_ready)
				@(posedge clk);
		end
		rx_valid <= 1'b0;
		rx_data <= ~f[f.size()-1];
	endtask
endmodule

// [tb/test_api_local_command_frames.sv]
`timescale 1ns/100ps
module test_api_local_command_frames
	import alcf_pkg::*;
;
	typedef logic [7:0] alcf_bq_t[$];
	logic       clk;
	logic       rst_n;
	logic [7:0] rx_data;
	logic       rx_valid;
	logic       rx_ready;
	logic [7:0] tx_data;
	logic       tx_valid;
	logic       tx_ready;
	logic       tx_done;
	logic [7:0] tx_done_id;
	logic [7:0] tx_done_status;
	logic       rf_rx_valid;
	logic [7:0] rf_rx_byte;
	logic       remote_done;
	logic [7:0] remote_id;
	logic       remote_delivered;
	logic [7:0] remote_status;
	logic [7:0] temp_value;
	logic [7:0] api_mode;
	logic [7:0] node_id;
	logic       frame_error;
	int         mismatches;
	int         n_checks;
	int         cycles;
	int         n_err;

	alcf_top u_dut (.clk(clk), .rst_n(rst_n), .rx_data(rx_data),
		.rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .tx_done(tx_done),
		.tx_done_id(tx_done_id), .tx_done_status(tx_done_status),
		.rf_rx_valid(rf_rx_valid), .rf_rx_byte(rf_rx_byte),
		.remote_done(remote_done), .remote_id(remote_id),
		.remote_delivered(remote_delivered),
		.remote_status(remote_status), .temp_value(temp_value),
		.api_mode(api_mode), .node_id(node_id),
		.frame_error(frame_error));
	alcf_host u_host (.clk(clk), .rx_ready(rx_ready), .tx_data(tx_data),
		.tx_valid(tx_valid), .rx_data(rx_data), .rx_valid(rx_valid),
		.tx_ready(tx_ready));

	always #20 clk = ~clk;
	// ========================================
	// cycle ceiling and error pulse count
	always @(posedge clk)
	begin
		cycles++;
		if (frame_error === 1'b1)
			n_err++;
		if (cycles == 20000)
		begin
			mismatches++;
			end_sim();
		end
	end
	// ========================================
	// shared tasks
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		n_checks++;
		if (g !== e)
		begin
			mismatches++;
			$display("ERROR %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic expect_frame(input alcf_bq_t b);
		alcf_bq_t e;
		logic [7:0] s;
		int n;
		s = 8'h00;
		foreach (b[i])
			s = s + b[i];
		e = {START_DELIM, 8'h00, 8'(b.size()), b, CKSUM_TOTAL - s};
		e = u_host.escape_q(e);
		n = 0;
		while (u_host.got.size() < e.size() && n < 300)
		begin
			@(posedge clk);
			n++;
		end
		foreach (e[i])
			if (i < u_host.got.size())
				chk(u_host.got[i], e[i]);
		repeat (20) @(posedge clk);
		chk(8'(u_host.got.size()), 8'(e.size()));
		u_host.got.delete();
	endtask
	task automatic expect_none();
		repeat (60) @(posedge clk);
		chk(8'(u_host.got.size()), 8'h00);
	endtask
	task automatic pulse(input int k);
		@(posedge clk);
		if (k == 0)
			tx_done <= 1'b1;
		else if (k == 1)
			remote_done <= 1'b1;
		else
			rf_rx_valid <= 1'b1;
		@(posedge clk);
		tx_done <= 1'b0;
		remote_done <= 1'b0;
		rf_rx_valid <= 1'b0;
	endtask
	// ========================================
	// scenarios
	task automatic t_query();
		u_host.send({T_LOCAL_NOW, 8'h17, 8'h41, 8'h50}, 1'b0);
		expect_frame({T_LOCAL_RESP, 8'h17, 8'h41, 8'h50, STATUS_OK,
			8'h01});
		u_host.send({T_LOCAL_QUEUE, 8'h18, 8'h54, 8'h50}, 1'b0);
		expect_frame({T_LOCAL_RESP, 8'h18, 8'h54, 8'h50, STATUS_OK,
			8'h2A});
		u_host.send({T_LOCAL_NOW, 8'h19, 8'h54, 8'h50, 8'h01},
			1'b0);
		expect_frame({T_LOCAL_RESP, 8'h19, 8'h54, 8'h50,
			STATUS_BAD_VAL});
		u_host.send({T_LOCAL_NOW, 8'h1A, 8'h5A, 8'h5A}, 1'b0);
		expect_frame({T_LOCAL_RESP, 8'h1A, 8'h5A, 8'h5A,
			STATUS_BAD_CMD});
		$display("query test done");
	endtask
	task automatic t_queue();
		u_host.stall = 1'b1;
		u_host.send({T_LOCAL_QUEUE, 8'h05, 8'h4E, 8'h49, 8'h33},
			1'b0);
		expect_frame({T_LOCAL_RESP, 8'h05, 8'h4E, 8'h49,
			STATUS_OK});
		chk(node_id, 8'h20);
		u_host.send({T_LOCAL_QUEUE, 8'h00, 8'h41, 8'h43}, 1'b0);
		expect_none();
		chk(node_id, 8'h33);
		u_host.send({T_LOCAL_QUEUE, 8'h07, 8'h4E, 8'h49, 8'h44},
			1'b0);
		expect_frame({T_LOCAL_RESP, 8'h07, 8'h4E, 8'h49,
			STATUS_OK});
		chk(node_id, 8'h33);
		u_host.send({T_LOCAL_NOW, 8'h08, 8'h41, 8'h50, 8'h01},
			1'b0);
		expect_frame({T_LOCAL_RESP, 8'h08, 8'h41, 8'h50,
			STATUS_OK});
		chk(node_id, 8'h44);
		u_host.stall = 1'b0;
		$display("queue test done");
	endtask
	task automatic t_now();
		u_host.send({T_LOCAL_NOW, 8'h00, 8'h41, 8'h50, 8'h05},
			1'b0);
		expect_none();
		chk(api_mode, 8'h05);
		rf_rx_byte <= 8'h5A;
		pulse(2);
		expect_frame({T_RX_EXPL, 8'h5A});
		u_host.send({T_LOCAL_NOW, 8'h09, 8'h41, 8'h50, 8'h00, 8'h01},
			1'b0);
		expect_frame({T_LOCAL_RESP, 8'h09, 8'h41, 8'h50,
			STATUS_OK});
		chk(api_mode, 8'h01);
		pulse(2);
		expect_frame({T_RX_STD, 8'h5A});
		$display("immediate test done");
	endtask
	task automatic t_bad();
		int k;
		k = n_err;
		u_host.send({T_LOCAL_NOW, 8'h0A, 8'h4E, 8'h49, 8'h77},
			1'b1);
		expect_none();
		chk(node_id, 8'h44);
		chk(8'(n_err - k), 8'h01);
		$display("checksum test done");
	endtask
	task automatic t_events();
		tx_done_id <= 8'h31;
		tx_done_status <= 8'h21;
		pulse(0);
		expect_frame({T_TX_STATUS, 8'h31, 8'h21});
		tx_done_id <= 8'h00;
		pulse(0);
		expect_none();
		remote_id <= 8'h32;
		remote_delivered <= 1'b0;
		pulse(1);
		expect_none();
		remote_delivered <= 1'b1;
		pulse(1);
		expect_frame({T_REMOTE_RESP, 8'h32, 8'h00});
		$display("event test done");
	endtask
	task automatic t_escape();
		u_host.send({T_LOCAL_NOW, 8'h0B, 8'h41, 8'h50, 8'h02},
			1'b0);
		u_host.escaped = 1'b1;
		expect_frame({T_LOCAL_RESP, 8'h0B, 8'h41, 8'h50,
			STATUS_OK});
		chk(api_mode, 8'h02);
		u_host.send({T_LOCAL_NOW, 8'h11, 8'h41, 8'h50}, 1'b0);
		expect_frame({T_LOCAL_RESP, 8'h11, 8'h41, 8'h50, STATUS_OK,
			8'h02});
		u_host.send({T_LOCAL_NOW, 8'h13, 8'h4E, 8'h49, 8'h7E},
			1'b0);
		expect_frame({T_LOCAL_RESP, 8'h13, 8'h4E, 8'h49,
			STATUS_OK});
		chk(node_id, 8'h7E);
		u_host.escaped = 1'b0;
		$display("escape test done");
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// ========================================
	// main sequence
	initial
	begin
		clk = 1'b0;
		rst_n = 1'b0;
		tx_done = 1'b0;
		tx_done_id = 8'h00;
		tx_done_status = 8'h00;
		rf_rx_valid = 1'b0;
		rf_rx_byte = 8'h00;
		remote_done = 1'b0;
		remote_id = 8'h00;
		remote_delivered = 1'b0;
		remote_status = 8'h00;
		temp_value = 8'h2A;
		repeat (16) @(posedge clk);
		chk(api_mode, 8'h01);
		chk(node_id, 8'h20);
		chk({7'h00, rx_ready}, 8'h01);
		chk({7'h00, tx_valid}, 8'h00);
		chk({7'h00, frame_error}, 8'h00);
		rst_n <= 1'b1;
		t_query();
		t_queue();
		t_now();
		t_bad();
		t_events();
		t_escape();
		end_sim();
	end
endmodule

// [verilog/alcf_pkg.sv]
package alcf_pkg;
	// ========================================
	// framing bytes
	localparam logic [7:0]  START_DELIM    = 8'h7E;
	localparam logic [7:0]  ESC_BYTE       = 8'h7D;
	localparam logic [7:0]  XON_BYTE       = 8'h11;
	localparam logic [7:0]  XOFF_BYTE      = 8'h13;
	localparam logic [7:0]  ESC_FLIP       = 8'h20;
	localparam logic [7:0]  CKSUM_TOTAL    = 8'hFF;
	// ========================================
	// frame types
	localparam logic [7:0]  T_LOCAL_NOW    = 8'h08;
	localparam logic [7:0]  T_LOCAL_QUEUE  = 8'h09;
	localparam logic [7:0]  T_LOCAL_RESP   = 8'h88;
	localparam logic [7:0]  T_TX_STATUS    = 8'h8B;
	localparam logic [7:0]  T_RX_STD       = 8'h90;
	localparam logic [7:0]  T_RX_EXPL      = 8'h91;
	localparam logic [7:0]  T_REMOTE_RESP  = 8'h97;
	// ========================================
	// field offsets and their index inside frame data
	localparam int          OFF_TYPE       = 3;
	localparam int          OFF_ID         = 4;
	localparam int          OFF_CMD        = 5;
	localparam int          OFF_VALUE      = 7;
	localparam logic [15:0] IDX_ID         = 16'(OFF_ID - OFF_TYPE);
	localparam logic [15:0] IDX_CMD_HI     = 16'(OFF_CMD - OFF_TYPE);
	localparam logic [15:0] IDX_CMD_LO     = 16'(OFF_CMD + 1 - OFF_TYPE);
	localparam logic [15:0] IDX_VALUE      = 16'(OFF_VALUE - OFF_TYPE);
	// ========================================
	// command codes and parameter table
	localparam int          PARAM_COUNT    = 2;
	localparam logic [15:0] CMD_API_MODE   = 16'h4150;
	localparam logic [15:0] CMD_NODE_ID    = 16'h4E49;
	localparam logic [15:0] CMD_APPLY      = 16'h4143;
	localparam logic [15:0] CMD_TEMP       = 16'h5450;
	localparam logic [15:0] PARAM_CODE [PARAM_COUNT] = '{CMD_API_MODE,
		CMD_NODE_ID};
	localparam logic [7:0]  PARAM_RESET [PARAM_COUNT] = '{8'h01, 8'h20};
	localparam logic [1:0]  API_MODE_ESCAPED = 2'h2;
	localparam int          API_EXPLICIT_BIT = 2;
	// ========================================
	// status codes and sizes
	localparam logic [7:0]  STATUS_OK      = 8'h00;
	localparam logic [7:0]  STATUS_BAD_CMD = 8'h02;
	localparam logic [7:0]  STATUS_BAD_VAL = 8'h03;
	localparam logic [2:0]  RESP_LEN_SET   = 3'h5;
	localparam logic [2:0]  RESP_LEN_QUERY = 3'h6;
	localparam logic [2:0]  EVT_LEN        = 3'h3;
	localparam logic [2:0]  RFR_LEN        = 3'h2;
	localparam int          BODY_MAX       = 6;
	localparam int          FIFO_DEPTH     = 32;
	localparam int          BYTE_W         = 8;

	typedef enum logic [2:0] {RX_DELIM, RX_LEN_HI, RX_LEN_LO, RX_DATA,
		RX_CKSUM, RX_EXEC} alcf_rx_state_t;
	typedef enum logic [2:0] {TX_IDLE, TX_DELIM, TX_LEN_HI, TX_LEN_LO,
		TX_BODY, TX_CKSUM} alcf_tx_state_t;
endpackage

// [verilog/alcf_top.sv]
`timescale 1ns/100ps

// ========================================
// output byte fifo with registered read stage
module alcf_fifo
	import alcf_pkg::*;
#(
	parameter int WIDTH = BYTE_W,
	parameter int DEPTH = FIFO_DEPTH
)(
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  in_ready,
	output logic                  out_valid,
	output logic      [WIDTH-1:0] out_data,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic             push;
	logic             pop;

	assign in_ready = (count != (AW+1)'(DEPTH));
	assign push     = in_valid && in_ready;
	assign pop      = (count != '0) && (!out_valid || out_ready);

	always_ff @(posedge clk)
	begin
		if (push)
			mem[wr_ptr] <= in_data;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end
		else
		begin
			if (push)
				wr_ptr <= wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
			if (push && !pop)
				count <= count + 1'b1;
			else if (pop && !push)
				count <= count - 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			out_valid <= 1'b0;
			out_data  <= '0;
		end
		else if (pop)
		begin
			out_valid <= 1'b1;
			out_data  <= mem[rd_ptr];
		end
		else if (out_ready)
			out_valid <= 1'b0;
	end
endmodule

// Behaviour
// - nonzero request identifier lets the host match responses to requests
// - identifier zero suppresses the response frame
// - transmit status frame follows each transmission unless id is zero
// - transmit status frame carries the failure reason
// - received payload frame type is standard or explicit per api mode
// - no remote response frame when the remote node missed the command
// - immediate local request applies a set value at once
// - request with no value after the command code is a read
// - read answer carries the currently active value
// - local response echoes the request identifier
// - type at offset 3, identifier at 4, two-byte command at 5
// - bytes from offset 7 are the new value; absent means read
// - checksum is 0xFF minus low byte of sum from offset 3
// - length field counts bytes between length and checksum
// - queued request values are held pending, not applied
// - pending values apply on immediate request or apply command
// - escaped mode sends escape byte then original XOR 0x20
// - frame failing the checksum is discarded unacted
// - multi-byte fields travel most significant byte first
module alcf_top
	import alcf_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic [7:0] rx_data,
	input  wire logic       rx_valid,
	output logic            rx_ready,
	output logic      [7:0] tx_data,
	output logic            tx_valid,
	input  wire logic       tx_ready,
	input  wire logic       tx_done,
	input  wire logic [7:0] tx_done_id,
	input  wire logic [7:0] tx_done_status,
	input  wire logic       rf_rx_valid,
	input  wire logic [7:0] rf_rx_byte,
	input  wire logic       remote_done,
	input  wire logic [7:0] remote_id,
	input  wire logic       remote_delivered,
	input  wire logic [7:0] remote_status,
	input  wire logic [7:0] temp_value,
	output logic      [7:0] api_mode,
	output logic      [7:0] node_id,
	output logic            frame_error
);
	alcf_rx_state_t rx_state;
	alcf_tx_state_t tx_state;
	logic [15:0] f_len;
	logic [15:0] idx;
	logic [7:0]  sum;
	logic [7:0]  f_type;
	logic [7:0]  f_id;
	logic [15:0] f_cmd;
	logic [7:0]  f_value;
	logic        val_present;
	logic        esc_seen;
	logic        exec;
	logic        take;
	logic        escaped_mode;
	logic        is_esc;
	logic        is_restart;
	logic        byte_ok;
	logic [7:0]  byte_val;
	logic [7:0]  active   [PARAM_COUNT];
	logic [7:0]  pend_val [PARAM_COUNT];
	logic [PARAM_COUNT-1:0] pend_valid;
	logic [PARAM_COUNT-1:0] hit;
	logic        is_local;
	logic        is_now;
	logic        is_apply;
	logic        is_temp;
	logic        apply_all;
	logic [7:0]  q_val;
	logic        resp_pend;
	logic [7:0]  resp_id;
	logic [15:0] resp_cmd;
	logic [7:0]  resp_status;
	logic        resp_has_val;
	logic [7:0]  resp_val;
	logic        txs_pend;
	logic [7:0]  txs_id;
	logic [7:0]  txs_status;
	logic        rem_pend;
	logic [7:0]  rem_id;
	logic [7:0]  rem_status;
	logic        rfr_pend;
	logic [7:0]  rfr_byte;
	logic        sel_resp;
	logic        sel_txs;
	logic        sel_rem;
	logic        sel_rfr;
	logic [7:0]  body [BODY_MAX];
	logic [2:0]  body_len;
	logic [2:0]  bi;
	logic [7:0]  osum;
	logic [7:0]  cur;
	logic        esc_second;
	logic        esc_needed;
	logic [7:0]  push_byte;
	logic        push;
	logic        fifo_ready;

	// ========================================
	// input byte decode and unescape
	assign take         = rx_valid && rx_ready;
	assign escaped_mode = (api_mode[1:0] == API_MODE_ESCAPED);
	assign is_esc       = take && escaped_mode && !esc_seen
		&& (rx_data == ESC_BYTE);
	assign is_restart   = take && (rx_data == START_DELIM)
		&& (escaped_mode || rx_state == RX_DELIM);
	assign byte_ok      = take && !is_esc && !is_restart;
	assign byte_val     = esc_seen ? (rx_data ^ ESC_FLIP) : rx_data;

	// ========================================
	// frame parser
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rx_state    <= RX_DELIM;
			rx_ready    <= 1'b1;
			esc_seen    <= 1'b0;
			f_len       <= '0;
			idx         <= '0;
			sum         <= '0;
			f_type      <= '0;
			f_id        <= '0;
			f_cmd       <= '0;
			f_value     <= '0;
			val_present <= 1'b0;
			exec        <= 1'b0;
			frame_error <= 1'b0;
		end
		else
		begin
			exec        <= 1'b0;
			frame_error <= 1'b0;
			if (take)
				esc_seen <= is_esc;
			if (is_restart)
				rx_state <= RX_LEN_HI;
			else if (byte_ok)
			begin
				case (rx_state)
				RX_LEN_HI:
				begin
					f_len[15:8] <= byte_val;
					rx_state    <= RX_LEN_LO;
				end
				RX_LEN_LO:
				begin
					f_len[7:0]  <= byte_val;
					idx         <= '0;
					sum         <= '0;
					val_present <= 1'b0;
					rx_state    <= ({f_len[15:8], byte_val} == '0)
						? RX_DELIM : RX_DATA;
				end
				RX_DATA:
				begin
					sum <= sum + byte_val;
					idx <= idx + 16'h0001;
					if (idx == '0)
						f_type <= byte_val;
					else if (idx == IDX_ID)
						f_id <= byte_val;
					else if (idx == IDX_CMD_HI)
						f_cmd[15:8] <= byte_val;
					else if (idx == IDX_CMD_LO)
						f_cmd[7:0] <= byte_val;
					else if (idx >= IDX_VALUE)
					begin
						f_value     <= byte_val;
						val_present <= 1'b1;
					end
					if (idx + 16'h0001 == f_len)
						rx_state <= RX_CKSUM;
				end
				RX_CKSUM:
				begin
					if (8'(sum + byte_val) == CKSUM_TOTAL)
					begin
						rx_state <= RX_EXEC;
						rx_ready <= 1'b0;
					end
					else
					begin
						frame_error <= 1'b1;
						rx_state    <= RX_DELIM;
					end
				end
				default:
					rx_state <= RX_DELIM;
				endcase
			end
			if (rx_state == RX_EXEC && !resp_pend)
			begin
				exec     <= 1'b1;
				rx_state <= RX_DELIM;
				rx_ready <= 1'b1;
			end
		end
	end

	// ========================================
	// local command decode
	assign is_now    = (f_type == T_LOCAL_NOW);
	assign is_local  = exec && (is_now || f_type == T_LOCAL_QUEUE)
		&& (f_len > IDX_CMD_LO);
	assign is_apply  = (f_cmd == CMD_APPLY);
	assign is_temp   = (f_cmd == CMD_TEMP);
	assign apply_all = is_local && (is_now || is_apply);

	always_comb
	begin
		q_val = temp_value;
		for (int i = 0; i < PARAM_COUNT; i++)
			if (hit[i])
				q_val = active[i];
	end

	// ========================================
	// parameter table, active and pending copies
	generate
		for (genvar g = 0; g < PARAM_COUNT; g++)
		begin : g_param
			assign hit[g] = (f_cmd == PARAM_CODE[g]);
			always_ff @(posedge clk or negedge rst_n)
			begin
				if (!rst_n)
				begin
					active[g]     <= PARAM_RESET[g];
					pend_val[g]   <= PARAM_RESET[g];
					pend_valid[g] <= 1'b0;
				end
				else
				begin
					if (is_local && !is_now && hit[g] && val_present)
					begin
						pend_val[g]   <= f_value;
						pend_valid[g] <= 1'b1;
					end
					if (apply_all && pend_valid[g])
					begin
						active[g]     <= pend_val[g];
						pend_valid[g] <= 1'b0;
					end
					if (is_local && is_now && hit[g] && val_present)
					begin
						active[g]     <= f_value;
						pend_valid[g] <= 1'b0;
					end
				end
			end
		end
	endgenerate

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			api_mode <= PARAM_RESET[0];
			node_id  <= PARAM_RESET[1];
		end
		else
		begin
			api_mode <= active[0];
			node_id  <= active[1];
		end
	end

	// ========================================
	// pending local response
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			resp_pend    <= 1'b0;
			resp_id      <= '0;
			resp_cmd     <= '0;
			resp_status  <= STATUS_OK;
			resp_has_val <= 1'b0;
			resp_val     <= '0;
		end
		else
		begin
			if (sel_resp)
				resp_pend <= 1'b0;
			if (is_local && f_id != '0)
			begin
				resp_pend    <= 1'b1;
				resp_id      <= f_id;
				resp_cmd     <= f_cmd;
				resp_has_val <= !val_present && !is_apply
					&& (|hit || is_temp);
				resp_val     <= q_val;
				if (!(|hit || is_apply || is_temp))
					resp_status <= STATUS_BAD_CMD;
				else if (is_temp && val_present)
					resp_status <= STATUS_BAD_VAL;
				else
					resp_status <= STATUS_OK;
			end
		end
	end

	// ========================================
	// outside events, set wins over clear
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			txs_pend   <= 1'b0;
			txs_id     <= '0;
			txs_status <= '0;
			rem_pend   <= 1'b0;
			rem_id     <= '0;
			rem_status <= '0;
			rfr_pend   <= 1'b0;
			rfr_byte   <= '0;
		end
		else
		begin
			if (sel_txs)
				txs_pend <= 1'b0;
			if (sel_rem)
				rem_pend <= 1'b0;
			if (sel_rfr)
				rfr_pend <= 1'b0;
			if (tx_done && tx_done_id != '0)
			begin
				txs_pend   <= 1'b1;
				txs_id     <= tx_done_id;
				txs_status <= tx_done_status;
			end
			if (remote_done && remote_delivered)
			begin
				rem_pend   <= 1'b1;
				rem_id     <= remote_id;
				rem_status <= remote_status;
			end
			if (rf_rx_valid)
			begin
				rfr_pend <= 1'b1;
				rfr_byte <= rf_rx_byte;
			end
		end
	end

	// ========================================
	// response frame emitter
	assign sel_resp = (tx_state == TX_IDLE) && resp_pend;
	assign sel_txs  = (tx_state == TX_IDLE) && !resp_pend && txs_pend;
	assign sel_rem  = (tx_state == TX_IDLE) && !resp_pend && !txs_pend
		&& rem_pend;
	assign sel_rfr  = (tx_state == TX_IDLE) && !resp_pend && !txs_pend
		&& !rem_pend && rfr_pend;

	always_comb
	begin
		case (tx_state)
		TX_DELIM:  cur = START_DELIM;
		TX_LEN_HI: cur = 8'h00;
		TX_LEN_LO: cur = {5'h00, body_len};
		TX_BODY:   cur = body[bi];
		TX_CKSUM:  cur = CKSUM_TOTAL - osum;
		default:   cur = 8'h00;
		endcase
	end

	assign esc_needed = escaped_mode && !esc_second && tx_state != TX_DELIM
		&& (cur == START_DELIM || cur == ESC_BYTE
		|| cur == XON_BYTE || cur == XOFF_BYTE);
	assign push_byte  = esc_needed ? ESC_BYTE
		: (esc_second ? (cur ^ ESC_FLIP) : cur);
	assign push       = (tx_state != TX_IDLE);

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tx_state   <= TX_IDLE;
			body_len   <= '0;
			bi         <= '0;
			osum       <= '0;
			esc_second <= 1'b0;
			for (int i = 0; i < BODY_MAX; i++)
				body[i] <= '0;
		end
		else if (tx_state == TX_IDLE)
		begin
			if (sel_resp)
			begin
				body[0]  <= T_LOCAL_RESP;
				body[1]  <= resp_id;
				body[2]  <= resp_cmd[15:8];
				body[3]  <= resp_cmd[7:0];
				body[4]  <= resp_status;
				body[5]  <= resp_val;
				body_len <= resp_has_val ? RESP_LEN_QUERY : RESP_LEN_SET;
			end
			else if (sel_txs || sel_rem)
			begin
				body[0]  <= sel_txs ? T_TX_STATUS : T_REMOTE_RESP;
				body[1]  <= sel_txs ? txs_id : rem_id;
				body[2]  <= sel_txs ? txs_status : rem_status;
				body_len <= EVT_LEN;
			end
			else if (sel_rfr)
			begin
				body[0]  <= api_mode[API_EXPLICIT_BIT]
					? T_RX_EXPL : T_RX_STD;
				body[1]  <= rfr_byte;
				body_len <= RFR_LEN;
			end
			if (sel_resp || sel_txs || sel_rem || sel_rfr)
				tx_state <= TX_DELIM;
		end
		else if (fifo_ready)
		begin
			esc_second <= esc_needed;
			if (!esc_needed)
			begin
				case (tx_state)
				TX_DELIM:  tx_state <= TX_LEN_HI;
				TX_LEN_HI: tx_state <= TX_LEN_LO;
				TX_LEN_LO:
				begin
					bi       <= '0;
					osum     <= '0;
					tx_state <= TX_BODY;
				end
				TX_BODY:
				begin
					osum <= osum + cur;
					bi   <= bi + 3'h1;
					if (bi + 3'h1 == body_len)
						tx_state <= TX_CKSUM;
				end
				default:   tx_state <= TX_IDLE;
				endcase
			end
		end
	end

	alcf_fifo #(
		.WIDTH (BYTE_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk       (clk),
		.rst_n     (rst_n),
		.in_valid  (push),
		.in_data   (push_byte),
		.in_ready  (fifo_ready),
		.out_valid (tx_valid),
		.out_data  (tx_data),
		.out_ready (tx_ready)
	);

	// ========================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_esc_first;
		push && fifo_ready && esc_needed;
	endsequence
	sequence s_esc_second(logic [7:0] orig);
		esc_second && push_byte == (orig ^ ESC_FLIP);
	endsequence
	sequence s_bad_sum;
		rx_state == RX_CKSUM && byte_ok
			&& 8'(sum + byte_val) != CKSUM_TOTAL;
	endsequence

	a_zero_id_quiet: assert property (is_local && f_id == '0 |=> !resp_pend)
		else $error("response raised for zero identifier");
	a_resp_id_echo: assert property (is_local && f_id != '0
		|=> resp_pend && resp_id == $past(f_id))
		else $error("response identifier mismatch");
	a_query_value: assert property (is_local && !val_present && |hit
		&& f_id != '0 |=> resp_has_val && resp_val == $past(q_val))
		else $error("query answer lacks active value");
	a_bad_cksum_drop: assert property (s_bad_sum |=> frame_error
		##1 !exec[*3])
		else $error("bad checksum frame acted on");
	a_immediate_set: assert property (is_local && is_now && hit[0]
		&& val_present |=> ##1 api_mode == $past(f_value, 2))
		else $error("immediate set not applied");
	a_queue_hold: assert property (is_local && !is_now && hit[0]
		&& val_present |=> pend_valid[0] && $stable(active[0]))
		else $error("queued value applied early");
	a_apply_pending: assert property (is_local && is_apply && pend_valid[0]
		|=> active[0] == $past(pend_val[0]) && !pend_valid[0])
		else $error("pending value not applied");
	a_tx_status_gate: assert property (tx_done && tx_done_id == '0
		&& !txs_pend |=> !txs_pend)
		else $error("status queued for zero identifier");
	a_remote_gate: assert property (remote_done && !remote_delivered
		&& !rem_pend |=> !rem_pend)
		else $error("remote response for undelivered command");
	a_escape_pair: assert property (s_esc_first |=> s_esc_second($past(cur)))
		else $error("escape byte not followed by flipped byte");
	a_rx_frame_type: assert property (sel_rfr |=> body[0] ==
		(api_mode[API_EXPLICIT_BIT] ? T_RX_EXPL : T_RX_STD))
		else $error("receive frame type wrong for mode");
endmodule
